// file: hw/wtpm_engine.sv
`timescale 1ns/10ps
// What this block does
// - Remove: copy entry to destination, pointer minus one
// - First table word is pointer, not data
// - Remove moves nothing once pointer is zero
// - One transfer per scan while enabled
// - Remove: flag on when pointer is zero
// - Flag lasts until reuse or scan end
// - Entry address is base plus pointer
// - Store: pointer plus one, source into entry
// - Store pointer at length wraps to one
// - Store moves nothing for pointer beyond length
// - Store: flag on when pointer equals length
// - Start zero stores into first data word
module wtpm_engine
	import wtpm_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic scan_start,
	input wire logic scan_end,
	input wire logic enable_contact,
	input wire logic op_sel,
	input wire logic [LEN_W-1:0] table_len,
	input wire logic [ADDR_W-1:0] table_base,
	input wire logic [ADDR_W-1:0] operand_addr,
	input wire logic host_req,
	input wire logic host_we,
	input wire logic [ADDR_W-1:0] host_addr,
	input wire logic [WORD_W-1:0] host_wdata,
	output logic host_ack_q,
	output logic [WORD_W-1:0] host_rdata_q,
	output logic table_status_flag_q,
	output logic busy_q,
	output logic done_q
);
	wtpm_state_e state_q, state_d;
	logic op_q, op_d;
	logic [LEN_W-1:0] len_q, len_d;
	logic [ADDR_W-1:0] base_q, base_d, opnd_q, opnd_d;
	logic [ADDR_W-1:0] rd_addr_q, rd_addr_d, dst_q, dst_d;
	logic [WORD_W-1:0] ptr_q, ptr_d, ptr_new_q, ptr_new_d;
	logic flag_new_q, flag_new_d, flag_d, flag_upd;
	logic busy_d, done_d, host_ack_d;
	logic [WORD_W-1:0] len_w;

	logic mem_we;
	logic [ADDR_W-1:0] mem_addr;
	logic [WORD_W-1:0] mem_wdata, mem_rdata;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [FIFO_W-1:0] fifo_out_data;
	logic host_take;

	// Single port memory shared by table, pointer and operands
	wtpm_mem #(.AW(MEM_AW), .DW(WORD_W)) u_mem (
		.mclk(mclk),
		.nrst(nrst),
		.we(mem_we),
		.addr(mem_addr[MEM_AW-1:0]),
		.wdata(mem_wdata),
		.rdata_q(mem_rdata)
	);

	// Moved word travels with its destination address
	wtpm_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.nrst(nrst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data({dst_q, mem_rdata}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	always_comb begin
		len_w = {{(WORD_W-LEN_W){1'b0}}, len_q};
	end

	// Port arbitration: engine steps first, then drain, host only when idle
	always_comb begin
		mem_we = 1'b0;
		mem_addr = ADDR_RESET;
		mem_wdata = WORD_RESET;
		fifo_out_ready = 1'b0;
		host_take = 1'b0;
		fifo_in_valid = (state_q == WTPM_GET_DATA);
		case (state_q)
			WTPM_RD_PTR: begin
				mem_addr = base_q;
			end
			WTPM_RD_DATA: begin
				mem_addr = rd_addr_q;
			end
			WTPM_WR_PTR: begin
				mem_we = 1'b1;
				mem_addr = base_q;
				mem_wdata = ptr_new_q;
			end
			default: begin
				if (fifo_out_valid) begin
					mem_we = 1'b1;
					mem_addr = fifo_out_data[FIFO_W-1:WORD_W];
					mem_wdata = fifo_out_data[WORD_W-1:0];
					fifo_out_ready = 1'b1;
				end else if (state_q == WTPM_IDLE && host_req) begin
					host_take = 1'b1;
					mem_we = host_we;
					mem_addr = host_addr;
					mem_wdata = host_wdata;
				end
			end
		endcase
	end

	always_comb begin
		state_d = state_q;
		op_d = op_q;
		len_d = len_q;
		base_d = base_q;
		opnd_d = opnd_q;
		rd_addr_d = rd_addr_q;
		dst_d = dst_q;
		ptr_d = ptr_q;
		ptr_new_d = ptr_new_q;
		flag_new_d = flag_new_q;
		flag_upd = 1'b0;
		flag_d = table_status_flag_q;
		done_d = 1'b0;
		host_ack_d = host_take;
		// Scan end clears; an operation in the same cycle overrides it
		if (scan_end) begin
			flag_d = 1'b0;
		end
		case (state_q)
			WTPM_IDLE: begin
				// Scan starts arriving mid operation are dropped; scans outlast it
				if (scan_start && enable_contact) begin
					op_d = op_sel;
					len_d = table_len;
					base_d = table_base;
					opnd_d = operand_addr;
					state_d = WTPM_RD_PTR;
				end
			end
			WTPM_RD_PTR: begin
				state_d = WTPM_GET_PTR;
			end
			WTPM_GET_PTR: begin
				ptr_d = mem_rdata;
				state_d = WTPM_RD_DATA;
				if (op_q == OP_REMOVE_BOTTOM) begin
					if (mem_rdata == PTR_ZERO) begin
						flag_upd = 1'b1;
						flag_d = 1'b1;
						state_d = WTPM_DONE;
					end else begin
						rd_addr_d = base_q + mem_rdata;
						dst_d = opnd_q;
						ptr_new_d = mem_rdata - PTR_STEP;
						flag_new_d = (mem_rdata == PTR_STEP);
					end
				end else begin
					if (len_q == LEN_ZERO || mem_rdata > len_w) begin
						flag_upd = 1'b1;
						flag_d = (mem_rdata == len_w);
						state_d = WTPM_DONE;
					end else begin
						// Zero only occurs before the first store, so entry one repeats
						if (mem_rdata == len_w) begin
							ptr_new_d = PTR_WRAP;
							dst_d = base_q + PTR_WRAP;
						end else begin
							ptr_new_d = mem_rdata + PTR_STEP;
							dst_d = base_q + mem_rdata + PTR_STEP;
						end
						rd_addr_d = opnd_q;
						flag_new_d = (ptr_new_d == len_w);
					end
				end
			end
			WTPM_RD_DATA: begin
				// Read only when the buffer has room, so the push cannot be refused
				if (fifo_in_ready) begin
					state_d = WTPM_GET_DATA;
				end
			end
			WTPM_GET_DATA: begin
				state_d = WTPM_WR_PTR;
			end
			WTPM_WR_PTR: begin
				flag_upd = 1'b1;
				flag_d = flag_new_q;
				state_d = WTPM_DONE;
			end
			WTPM_DONE: begin
				done_d = 1'b1;
				state_d = WTPM_IDLE;
			end
			default: begin
				state_d = WTPM_IDLE;
			end
		endcase
		busy_d = (state_d != WTPM_IDLE);
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= WTPM_IDLE;
			op_q <= OP_REMOVE_BOTTOM;
			len_q <= LEN_ZERO;
			base_q <= ADDR_RESET;
			opnd_q <= ADDR_RESET;
			rd_addr_q <= ADDR_RESET;
			dst_q <= ADDR_RESET;
			ptr_q <= WORD_RESET;
			ptr_new_q <= WORD_RESET;
			flag_new_q <= 1'b0;
			table_status_flag_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			host_ack_q <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			len_q <= len_d;
			base_q <= base_d;
			opnd_q <= opnd_d;
			rd_addr_q <= rd_addr_d;
			dst_q <= dst_d;
			ptr_q <= ptr_d;
			ptr_new_q <= ptr_new_d;
			flag_new_q <= flag_new_d;
			table_status_flag_q <= flag_d;
			busy_q <= busy_d;
			done_q <= done_d;
			host_ack_q <= host_ack_d;
		end
	end

	always_comb begin
		host_rdata_q = mem_rdata;
	end

	// Pushes within one operation; a second would repeat a transfer in one scan
	logic [1:0] push_cnt_q, push_cnt_d;

	always_comb begin
		push_cnt_d = push_cnt_q;
		if (state_q == WTPM_IDLE) begin
			push_cnt_d = 2'h0;
		end else if (fifo_in_valid && fifo_in_ready && push_cnt_q != 2'h3) begin
			push_cnt_d = push_cnt_q + 2'h1;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			push_cnt_q <= 2'h0;
		end else begin
			push_cnt_q <= push_cnt_d;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	a_flag_scan_clear: assert property (scan_end && !flag_upd |=> !table_status_flag_q)
		else $error("flag survived scan end");
	a_rb_zero_stop: assert property (state_q == WTPM_GET_PTR && op_q == OP_REMOVE_BOTTOM
		&& mem_rdata == PTR_ZERO |=> table_status_flag_q && state_q == WTPM_DONE)
		else $error("remove ran with zero pointer");
	a_rb_last_flag: assert property (state_q == WTPM_WR_PTR && op_q == OP_REMOVE_BOTTOM
		|=> table_status_flag_q == (ptr_q == PTR_STEP))
		else $error("remove flag wrong");
	a_rb_decrement: assert property (state_q == WTPM_WR_PTR && op_q == OP_REMOVE_BOTTOM
		|-> mem_we && mem_addr == base_q && mem_wdata == ptr_q - PTR_STEP)
		else $error("remove pointer not decremented");
	a_rb_entry_addr: assert property (state_q == WTPM_RD_DATA && op_q == OP_REMOVE_BOTTOM
		|-> mem_addr == base_q + ptr_q)
		else $error("remove entry address wrong");
	a_ptr_word_read: assert property (state_q == WTPM_RD_PTR |-> mem_addr == base_q && !mem_we)
		else $error("pointer not read from base");
	a_stt_wrap_one: assert property (state_q == WTPM_WR_PTR && op_q == OP_SOURCE_TO_TABLE
		&& ptr_q == len_w |-> mem_wdata == PTR_WRAP && dst_q == base_q + PTR_WRAP)
		else $error("store pointer did not wrap to one");
	a_stt_increment: assert property (state_q == WTPM_WR_PTR && op_q == OP_SOURCE_TO_TABLE
		&& ptr_q != len_w |-> mem_wdata == ptr_q + PTR_STEP)
		else $error("store pointer not incremented");
	a_stt_range: assert property (state_q == WTPM_GET_PTR && op_q == OP_SOURCE_TO_TABLE
		&& mem_rdata > len_w |=> state_q == WTPM_DONE ##1 !fifo_out_valid)
		else $error("store moved data out of range");
	a_stt_len_flag: assert property (state_q == WTPM_WR_PTR && op_q == OP_SOURCE_TO_TABLE
		|=> table_status_flag_q == ($past(ptr_new_q) == len_w))
		else $error("store flag wrong");
	a_scan_bounded: assert property (state_q == WTPM_IDLE && scan_start && enable_contact
		|=> busy_q ##[3:12] done_q)
		else $error("scan transfer not completed in time");
	a_one_push: assert property (state_q == WTPM_WR_PTR |-> push_cnt_q == 2'h1)
		else $error("transfer count per scan wrong");
	a_push_room: assert property (state_q == WTPM_GET_DATA |-> fifo_in_ready)
		else $error("moved word refused by buffer");
	a_done_pulse: assert property (done_q |=> !done_q)
		else $error("done held past one cycle");
	a_busy_done: assert property (done_q |-> !busy_q)
		else $error("busy still set at done");
	a_op_hold: assert property (state_q != WTPM_IDLE && $past(state_q) != WTPM_IDLE
		|-> $stable(op_q) && $stable(base_q))
		else $error("operation changed mid transfer");
	a_args_taken: assert property (state_q == WTPM_RD_PTR
		|-> len_q == $past(table_len) && opnd_q == $past(operand_addr))
		else $error("operation arguments not taken at scan start");
	a_rb_dest_sel: assert property (state_q == WTPM_GET_DATA && op_q == OP_REMOVE_BOTTOM
		|-> dst_q == opnd_q && fifo_in_valid)
		else $error("remove word not routed to destination");
	a_stt_src_read: assert property (state_q == WTPM_RD_DATA && op_q == OP_SOURCE_TO_TABLE
		|-> mem_addr == opnd_q && !mem_we)
		else $error("store source not read");
	a_stt_entry_addr: assert property (state_q == WTPM_WR_PTR && op_q == OP_SOURCE_TO_TABLE
		|-> dst_q == base_q + mem_wdata)
		else $error("store entry address wrong");
	a_drain_dest: assert property (state_q == WTPM_DONE && fifo_out_valid
		|-> mem_we && mem_addr == dst_q)
		else $error("moved word not written to its address");
	a_rb_zero_hold: assert property (state_q == WTPM_GET_PTR && op_q == OP_REMOVE_BOTTOM
		&& mem_rdata == PTR_ZERO |=> !mem_we && !fifo_out_valid)
		else $error("remove wrote with zero pointer");
	a_flag_hold: assert property (!scan_end && !flag_upd
		|=> $stable(table_status_flag_q))
		else $error("flag changed without cause");

	// Main scenarios: move, wrap, zero stop, scan end clear, out of range
	c_remove_move: cover property (state_q == WTPM_WR_PTR && op_q == OP_REMOVE_BOTTOM);
	c_store_wrap: cover property (state_q == WTPM_WR_PTR && op_q == OP_SOURCE_TO_TABLE
		&& ptr_q == len_w);
	c_zero_flag: cover property (state_q == WTPM_GET_PTR && op_q == OP_REMOVE_BOTTOM
		&& mem_rdata == PTR_ZERO);
	c_flag_clear: cover property (table_status_flag_q && scan_end);
	c_store_range: cover property (state_q == WTPM_GET_PTR && op_q == OP_SOURCE_TO_TABLE
		&& mem_rdata > len_w);
endmodule

// file: hw/wtpm_pkg.sv
package wtpm_pkg;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 16;
	localparam int MEM_AW = 10;
	localparam int LEN_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_W = ADDR_W + WORD_W;
	localparam logic OP_REMOVE_BOTTOM = 1'b0;
	localparam logic OP_SOURCE_TO_TABLE = 1'b1;
	localparam logic [WORD_W-1:0] PTR_ZERO = 16'h0000;
	localparam logic [WORD_W-1:0] PTR_STEP = 16'h0001;
	localparam logic [WORD_W-1:0] PTR_WRAP = 16'h0001;
	localparam logic [LEN_W-1:0] LEN_ZERO = 8'h00;
	localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
	localparam int SCAN_CYCLES_MAX = 8;
	typedef enum logic [2:0] {
		WTPM_IDLE,
		WTPM_RD_PTR,
		WTPM_GET_PTR,
		WTPM_RD_DATA,
		WTPM_GET_DATA,
		WTPM_WR_PTR,
		WTPM_DONE
	} wtpm_state_e;
endpackage

// file: hw/wtpm_mem.sv
`timescale 1ns/10ps
module wtpm_mem
	import wtpm_pkg::*;
#(
	parameter int AW = MEM_AW,
	parameter int DW = WORD_W
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata_q
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rdata_d;

	always_comb begin
		rdata_d = we ? rdata_q : mem[addr];
	end

	// Array left unreset so it maps onto plain RAM
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end
endmodule

// file: hw/wtpm_fifo.sv
`timescale 1ns/10ps
module wtpm_fifo
	import wtpm_pkg::*;
#(
	parameter int W = FIFO_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] buf_q [0:DEPTH-1];
	logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [PW:0] cnt_q, cnt_d;
	logic push, pop;

	always_comb begin
		in_ready = (cnt_q != DEPTH[PW:0]);
		out_valid = (cnt_q != '0);
		out_data = buf_q[rd_q];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			buf_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end
endmodule

// file: tb/wtpm_scan_model.sv
`timescale 1ns/10ps
module wtpm_scan_model
	import wtpm_pkg::*;
(
	input wire logic mclk,
	input wire logic done_q,
	input wire logic busy_q,
	input wire logic table_status_flag_q,
	output logic scan_start,
	output logic scan_end,
	output logic enable_contact,
	output logic op_sel,
	output logic [LEN_W-1:0] table_len,
	output logic [ADDR_W-1:0] table_base,
	output logic [ADDR_W-1:0] operand_addr
);
	initial begin
		scan_start = 1'b0;
		scan_end = 1'b0;
		enable_contact = 1'b0;
		op_sel = 1'b0;
		table_len = LEN_ZERO;
		table_base = ADDR_RESET;
		operand_addr = ADDR_RESET;
	end
	// One program scan; n stays 0 when no done pulse comes
	task automatic scan(input logic en, input logic op, input logic [LEN_W-1:0] len,
		input logic [ADDR_W-1:0] base, input logic [ADDR_W-1:0] opnd,
		output int n, output int nb, output logic flag);
		n = 0;
		nb = 0;
		flag = 1'b0;
		@(posedge mclk);
		enable_contact <= en;
		op_sel <= op;
		table_len <= len;
		table_base <= base;
		operand_addr <= opnd;
		scan_start <= 1'b1;
		@(posedge mclk);
		scan_start <= 1'b0;
		// A value read at an edge was launched one edge earlier
		for (int i = 0; i < 12 && n == 0; i++) begin
			@(posedge mclk);
			if (busy_q === 1'b1) begin
				nb++;
			end
			if (done_q === 1'b1) begin
				n = i;
				flag = table_status_flag_q;
			end
		end
		// Scan closes only after the operation, as a real program would
		scan_end <= 1'b1;
		@(posedge mclk);
		scan_end <= 1'b0;
		enable_contact <= 1'b0;
		@(posedge mclk);
	endtask
endmodule

// file: tb/word_table_pointer_mover_test.sv
`timescale 1ns/10ps
module word_table_pointer_mover_test;
	import wtpm_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic scan_start, scan_end, enable_contact, op_sel;
	logic [LEN_W-1:0] table_len;
	logic [ADDR_W-1:0] table_base, operand_addr;
	logic host_req = 1'b0;
	logic host_we = 1'b0;
	logic [ADDR_W-1:0] host_addr = ADDR_RESET;
	logic [WORD_W-1:0] host_wdata = WORD_RESET;
	logic host_ack_q, table_status_flag_q, busy_q, done_q;
	logic [WORD_W-1:0] host_rdata_q;
	int n_mismatch = 0;
	int checks_done = 0;
	always #25 mclk = ~mclk;
	wtpm_engine dut_u (.mclk(mclk), .nrst(nrst), .scan_start(scan_start), .scan_end(scan_end),
		.enable_contact(enable_contact), .op_sel(op_sel), .table_len(table_len),
		.table_base(table_base), .operand_addr(operand_addr), .host_req(host_req),
		.host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
		.host_ack_q(host_ack_q), .host_rdata_q(host_rdata_q),
		.table_status_flag_q(table_status_flag_q), .busy_q(busy_q), .done_q(done_q));
	wtpm_scan_model prog_u (.mclk(mclk), .done_q(done_q), .busy_q(busy_q),
		.table_status_flag_q(table_status_flag_q), .scan_start(scan_start),
		.scan_end(scan_end), .enable_contact(enable_contact), .op_sel(op_sel),
		.table_len(table_len), .table_base(table_base), .operand_addr(operand_addr));
	task automatic end_of_test();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] e);
		checks_done++;
		if (seen !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, seen);
		end
	endtask
	// Request held until ack is sampled; refused while the engine drains
	task automatic host(input logic we, input logic [ADDR_W-1:0] a,
		input logic [WORD_W-1:0] d, output logic [WORD_W-1:0] q);
		int i;
		i = 0;
		@(posedge mclk);
		host_req <= 1'b1;
		host_we <= we;
		host_addr <= a;
		host_wdata <= d;
		do begin
			@(posedge mclk);
			i++;
		end while (host_ack_q !== 1'b1 && i < 20);
		q = host_rdata_q;
		host_req <= 1'b0;
		if (i >= 20) begin
			n_mismatch++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
		logic [WORD_W-1:0] q;
		host(1'b1, a, d, q);
	endtask
	task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] e);
		logic [WORD_W-1:0] q;
		host(1'b0, a, 16'h0000, q);
		chk(nm, q, e);
	endtask
	task automatic op(input logic en, input logic o, input logic [ADDR_W-1:0] opnd,
		input int n_exp, input logic f_exp);
		int n;
		int nb;
		logic f;
		prog_u.scan(en, o, 8'h03, 16'h0100, opnd, n, nb, f);
		chk("cycles", n[WORD_W-1:0], n_exp[WORD_W-1:0]);
		chk("busy", nb[WORD_W-1:0], n_exp[WORD_W-1:0]);
		chk("flag", {15'h0000, f}, {15'h0000, f_exp});
		chk("flag_end", {15'h0000, table_status_flag_q}, 16'h0000);
	endtask
	task automatic t_store();
		wr(16'h0100, 16'h0000);
		for (int k = 1; k <= 4; k++) begin
			wr(16'h0200, 16'hA000 + k[WORD_W-1:0]);
			op(1'b1, OP_SOURCE_TO_TABLE, 16'h0200, 6, k == 3);
			rd("ptr", 16'h0100, (k == 4) ? 16'h0001 : k[WORD_W-1:0]);
			rd("entry", 16'h0100 + ((k == 4) ? 16'h0001 : k[WORD_W-1:0]),
				16'hA000 + k[WORD_W-1:0]);
		end
		wr(16'h0100, 16'h0005);
		op(1'b1, OP_SOURCE_TO_TABLE, 16'h0200, 3, 1'b0);
		rd("ptr_out", 16'h0100, 16'h0005);
		rd("entry_kept", 16'h0101, 16'hA004);
	endtask
	task automatic t_remove();
		wr(16'h0101, 16'h1111);
		wr(16'h0102, 16'h2222);
		wr(16'h0100, 16'h0002);
		for (int k = 2; k >= 0; k--) begin
			op(1'b1, OP_REMOVE_BOTTOM, 16'h0300, (k > 0) ? 6 : 3, k < 2);
			rd("dest", 16'h0300, (k > 0) ? 16'h1111 * k[WORD_W-1:0] : 16'h1111);
			rd("ptr", 16'h0100, (k > 0) ? k[WORD_W-1:0] - 16'h0001 : 16'h0000);
		end
		// Enable low: the scan passes without any transfer
		wr(16'h0100, 16'h0001);
		op(1'b0, OP_REMOVE_BOTTOM, 16'h0300, 0, 1'b0);
		rd("ptr_idle", 16'h0100, 16'h0001);
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		t_store();
		t_remove();
		end_of_test();
	end
endmodule
